// >>> verilog/arsq_pkg.sv
// Overview of operation
// - Reset input low with mode select low enters asynchronous reset at once, without filtering.
// - Entry drives reset output low, cancels holds, aborts cycles, floats pins, port high.
// - Entry does not need a running clock; it acts asynchronously.
// - Internal boot keeps internal reset until flash init completes, at most 1 ms.
// - External boot releases internal reset 3 to 8 half-periods after filtered rise.
// - Flash reads during init return FFFFh first, then 009Bh, which may trap.
// - Reset is asynchronous if mode select is low or falls low while input low.
// - Exit latches configuration port and drives bus strobes inactive.
// - After reset, fetching starts at address 00'0000h in code segment 0.
// - Input low with mode select high is a warm reset, not handled here.
package arsq_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned FLASH_INIT_US = 1000;
  localparam int unsigned FLASH_INIT_CYC = (FLASH_INIT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned FLASH_BLANK_CYC = FLASH_INIT_CYC / 4;
  localparam int unsigned EXIT_HALF_MIN = 3;
  localparam int unsigned EXIT_HALF_MAX = 8;
  localparam int unsigned EXIT_HALF_SEL = 4;
  localparam int unsigned EXIT_CYC = (EXIT_HALF_SEL + 1) / 2;
  localparam logic [15:0] FLASH_BLANK_WORD = 16'hFFFF;
  localparam logic [15:0] FLASH_BUSY_WORD = 16'h009B;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;
  localparam logic [7:0] RESET_SEGMENT = 8'h00;
  localparam int unsigned CFG_WIDTH = 16;
  localparam logic [15:0] CFG_PULL_VALUE = 16'hFFFF;
  typedef enum logic [1:0] {
    ARSQ_RESET = 2'b00,
    ARSQ_EXIT = 2'b01,
    ARSQ_FLASH = 2'b11,
    ARSQ_RUN = 2'b10
  } arsq_state_t;
endpackage : arsq_pkg

// >>> verilog/arsq_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser with agreement of the last two stages
module arsq_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule : arsq_sync

// >>> verilog/arsq_async_reset_sequencer.sv
`timescale 1ns/1ps
module arsq_async_reset_sequencer #(
  parameter int unsigned FLASH_INIT_CYC = arsq_pkg::FLASH_INIT_CYC,
  parameter int unsigned EXIT_CYC = arsq_pkg::EXIT_CYC
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic reset_input_n_i,
  input wire logic reset_mode_select_i,
  input wire logic external_access_select_n_i,
  input wire logic [15:0] configuration_port_i,
  output logic reset_output_n_o,
  output logic core_reset_n_o,
  output logic bus_abort_o,
  output logic hold_cancel_o,
  output logic pins_oe_n_o,
  output logic [15:0] configuration_port_o,
  output logic configuration_port_oe_o,
  output logic [15:0] system_config_o,
  output logic config_valid_o,
  output logic ale_o,
  output logic read_strobe_n_o,
  output logic write_strobes_n_o,
  output logic [23:0] fetch_address_o,
  output logic [7:0] code_segment_o,
  output logic flash_ready_o,
  output logic [15:0] flash_busy_word_o
);
  if (FLASH_INIT_CYC < 8 || EXIT_CYC < 1 || EXIT_CYC > 4) begin : g_bad_param
    $error("arsq: unsupported count parameters");
  end

  localparam int unsigned CW = $clog2(FLASH_INIT_CYC + 1);
  localparam logic [CW-1:0] FLASH_LAST = CW'(FLASH_INIT_CYC - 1);
  localparam logic [CW-1:0] BLANK_LAST = CW'(FLASH_INIT_CYC / 4);
  localparam logic [CW-1:0] EXIT_LAST = CW'(EXIT_CYC - 1);

  // Asynchronous entry: pin low with mode select low, no clock needed
  // Mode select high leaves the pin to the warm reset logic elsewhere
  wire async_entry_n = reset_input_n_i | reset_mode_select_i;
  wire dev_rst_n = arst_n_i & async_entry_n;

  // Reset input release, seen through the filter synchroniser
  logic rin_sync;
  arsq_sync #(.RST_VAL(1'b0)) u_sync (
    .mclk_i(mclk_i),
    .arst_n_i(dev_rst_n),
    .d_i(reset_input_n_i),
    .q_o(rin_sync)
  );

  // Boot select and configuration pads keep following while the core is held
  localparam int unsigned PIN_W = arsq_pkg::CFG_WIDTH + 1;
  wire [PIN_W-1:0] pin_raw = {external_access_select_n_i, configuration_port_i};
  wire [PIN_W-1:0] pin_sync;
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_pin_sync
      arsq_sync #(.RST_VAL(1'b1)) u_pin_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .d_i(pin_raw[gi]),
        .q_o(pin_sync[gi])
      );
    end
  endgenerate
  wire ea_sync_n = pin_sync[PIN_W-1];
  wire [15:0] cfg_sync = pin_sync[15:0];

  arsq_pkg::arsq_state_t state;
  arsq_pkg::arsq_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic ext_boot;

  wire cnt_done_exit = (cnt == EXIT_LAST);
  wire cnt_done_flash = (cnt == FLASH_LAST);
  wire in_run = (state == arsq_pkg::ARSQ_RUN);
  wire flash_live = in_run || (state == arsq_pkg::ARSQ_FLASH && cnt_done_flash);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      arsq_pkg::ARSQ_RESET: begin
        next_cnt = '0;
        if (rin_sync) begin
          next_state = arsq_pkg::ARSQ_EXIT;
        end
      end
      arsq_pkg::ARSQ_EXIT: begin
        next_cnt = cnt + CW'(1);
        if (cnt_done_exit) begin
          next_cnt = '0;
          next_state = ext_boot ? arsq_pkg::ARSQ_RUN : arsq_pkg::ARSQ_FLASH;
        end
      end
      arsq_pkg::ARSQ_FLASH: begin
        next_cnt = cnt + CW'(1);
        if (cnt_done_flash) begin
          next_cnt = cnt;
          if (!ext_boot) begin
            next_state = arsq_pkg::ARSQ_RUN;
          end
        end
      end
      arsq_pkg::ARSQ_RUN: begin
        next_cnt = (cnt_done_flash) ? cnt : cnt + CW'(1);
      end
      default: begin
        next_state = arsq_pkg::ARSQ_RESET;
        next_cnt = '0;
      end
    endcase
  end

  // In external boot the flash keeps initialising in the background
  wire ext_flash_done = ext_boot ? (in_run && cnt_done_flash) : flash_live;
  wire leaving = (next_state == arsq_pkg::ARSQ_RUN) && !in_run;
  wire [15:0] busy_word = (cnt < BLANK_LAST) ? arsq_pkg::FLASH_BLANK_WORD
                                             : arsq_pkg::FLASH_BUSY_WORD;

  wire in_reset = (state == arsq_pkg::ARSQ_RESET);

  // Sequence state; held at its start while the entry condition stands
  always_ff @(posedge mclk_i or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      state <= arsq_pkg::ARSQ_RESET;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Boot source follows the synchronised pin until the exit count starts
  always_ff @(posedge mclk_i or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      ext_boot <= 1'b0;
    end else if (in_reset) begin
      ext_boot <= !ea_sync_n;
    end
  end

  // Core and board reset are released together, on the edge that enters run
  always_ff @(posedge mclk_i or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      core_reset_n_o <= 1'b0;
      reset_output_n_o <= 1'b0;
    end else if (leaving) begin
      core_reset_n_o <= 1'b1;
      reset_output_n_o <= 1'b1;
    end
  end

  // Holds cancelled, bus cycles aborted and pads floated for the whole reset
  always_ff @(posedge mclk_i or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      bus_abort_o <= 1'b1;
      hold_cancel_o <= 1'b1;
      pins_oe_n_o <= 1'b1;
    end else if (leaving) begin
      bus_abort_o <= 1'b0;
      hold_cancel_o <= 1'b0;
      pins_oe_n_o <= 1'b0;
    end
  end

  // System configuration is taken once, from the synchronised port
  always_ff @(posedge mclk_i or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      system_config_o <= '0;
      config_valid_o <= 1'b0;
    end else if (leaving) begin
      system_config_o <= cfg_sync;
      config_valid_o <= 1'b1;
    end
  end

  // Bus strobes stay inactive; the core takes them over after release
  always_ff @(posedge mclk_i or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      ale_o <= 1'b0;
      read_strobe_n_o <= 1'b1;
      write_strobes_n_o <= 1'b1;
    end else begin
      ale_o <= 1'b0;
      read_strobe_n_o <= 1'b1;
      write_strobes_n_o <= 1'b1;
    end
  end

  // First fetch comes from the reset vector in segment zero
  always_ff @(posedge mclk_i or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      fetch_address_o <= arsq_pkg::RESET_VECTOR;
      code_segment_o <= arsq_pkg::RESET_SEGMENT;
    end else begin
      fetch_address_o <= arsq_pkg::RESET_VECTOR;
      code_segment_o <= arsq_pkg::RESET_SEGMENT;
    end
  end

  // Configuration pads only ever see the weak pull-up, never a driver
  always_ff @(posedge mclk_i or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      configuration_port_o <= arsq_pkg::CFG_PULL_VALUE;
      configuration_port_oe_o <= 1'b0;
    end else begin
      configuration_port_o <= arsq_pkg::CFG_PULL_VALUE;
      configuration_port_oe_o <= 1'b0;
    end
  end

  // Flash status, for reads that reach the array before its init is over
  always_ff @(posedge mclk_i or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      flash_ready_o <= 1'b0;
      flash_busy_word_o <= arsq_pkg::FLASH_BLANK_WORD;
    end else begin
      flash_ready_o <= ext_flash_done;
      flash_busy_word_o <= busy_word;
    end
  end
endmodule : arsq_async_reset_sequencer

// >>> testbench/arsq_board.sv
`timescale 1ns/1ps
module arsq_board (
  output logic rst_n_o,
  output logic mode_o,
  output logic ea_n_o,
  output logic [15:0] cfg_o
);
  // Power-up: reset and mode pins grounded until told otherwise
  initial begin
    rst_n_o = 1'b0;
    mode_o = 1'b0;
    ea_n_o = 1'b0;
    cfg_o = 16'hA5C3;
  end
  task automatic set(input logic r, input logic m, input logic e, input logic [15:0] c);
    rst_n_o = r;
    mode_o = m;
    ea_n_o = e;
    cfg_o = c;
  endtask : set
endmodule : arsq_board

// >>> testbench/arsq_props.sv
`timescale 1ns/1ps
module arsq_props #(
  parameter int unsigned FLASH_INIT_CYC = 40
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic reset_input_n_i,
  input wire logic reset_mode_select_i,
  input wire logic external_access_select_n_i,
  input wire logic [15:0] configuration_port_i,
  input wire logic reset_output_n_o,
  input wire logic core_reset_n_o,
  input wire logic bus_abort_o,
  input wire logic hold_cancel_o,
  input wire logic pins_oe_n_o,
  input wire logic [15:0] configuration_port_o,
  input wire logic [15:0] system_config_o,
  input wire logic config_valid_o,
  input wire logic [23:0] fetch_address_o,
  input wire logic [7:0] code_segment_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // Edges seen with the reset pin high while the core is still held
  int unsigned cnt;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt <= '0;
    else cnt <= (reset_input_n_i && !core_reset_n_o) ? cnt + 32'h1 : '0;
  end
  AST_ENTRY: assert property (!reset_input_n_i && !reset_mode_select_i |->
    !reset_output_n_o && !core_reset_n_o && bus_abort_o && hold_cancel_o && pins_oe_n_o)
    else $error("reset entry outputs wrong");
  AST_PULL: assert property (!reset_output_n_o |-> configuration_port_o == 16'hFFFF)
    else $error("config port not pulled high");
  AST_EXT: assert property ($rose(core_reset_n_o) && !external_access_select_n_i |->
    cnt > 3 && cnt < 13) else $error("external boot exit timing wrong");
  AST_FLASH: assert property ($rose(core_reset_n_o) && external_access_select_n_i |->
    cnt > FLASH_INIT_CYC && cnt < FLASH_INIT_CYC + 16) else $error("flash hold wrong");
  AST_LATCH: assert property ($rose(config_valid_o) |->
    system_config_o == $past(configuration_port_i)) else $error("config not latched");
  AST_OUT: assert property ($rose(core_reset_n_o) |->
    reset_output_n_o && !pins_oe_n_o && config_valid_o) else $error("exit outputs wrong");
  AST_FETCH: assert property (core_reset_n_o |->
    fetch_address_o == 24'h000000 && code_segment_o == 8'h00) else $error("bad start address");
  AST_WARM: assert property (core_reset_n_o && reset_mode_select_i ##1 reset_mode_select_i
    |-> core_reset_n_o) else $error("warm reset acted");
  COV_EXT: cover property ($rose(core_reset_n_o) && !external_access_select_n_i);
  COV_INT: cover property ($rose(core_reset_n_o) && external_access_select_n_i);
  COV_WARM: cover property (core_reset_n_o && !reset_input_n_i && reset_mode_select_i);
endmodule : arsq_props
bind arsq_async_reset_sequencer arsq_props #(.FLASH_INIT_CYC(FLASH_INIT_CYC)) i_props (
  .mclk_i(mclk_i),
  .arst_n_i(arst_n_i),
  .reset_input_n_i(reset_input_n_i),
  .reset_mode_select_i(reset_mode_select_i),
  .external_access_select_n_i(external_access_select_n_i),
  .configuration_port_i(configuration_port_i),
  .reset_output_n_o(reset_output_n_o),
  .core_reset_n_o(core_reset_n_o),
  .bus_abort_o(bus_abort_o),
  .hold_cancel_o(hold_cancel_o),
  .pins_oe_n_o(pins_oe_n_o),
  .configuration_port_o(configuration_port_o),
  .system_config_o(system_config_o),
  .config_valid_o(config_valid_o),
  .fetch_address_o(fetch_address_o),
  .code_segment_o(code_segment_o)
);

// >>> testbench/tb_async_reset_sequencer.sv
`timescale 1ns/1ps
module tb_async_reset_sequencer;
  logic mclk_i, arst_n_i, clk_en, reset_input_n_i, reset_mode_select_i, config_valid_o;
  logic external_access_select_n_i, reset_output_n_o, core_reset_n_o, bus_abort_o;
  logic hold_cancel_o, pins_oe_n_o, configuration_port_oe_o, ale_o, flash_ready_o;
  logic read_strobe_n_o, write_strobes_n_o;
  logic [15:0] configuration_port_i, configuration_port_o, system_config_o, flash_busy_word_o;
  logic [23:0] fetch_address_o;
  logic [7:0] code_segment_o;
  logic [1:0] sf;
  int fails, checks_done, n;
  arsq_async_reset_sequencer #(.FLASH_INIT_CYC(40)) i_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reset_input_n_i(reset_input_n_i),
    .reset_mode_select_i(reset_mode_select_i),
    .external_access_select_n_i(external_access_select_n_i),
    .configuration_port_i(configuration_port_i), .reset_output_n_o(reset_output_n_o),
    .core_reset_n_o(core_reset_n_o), .bus_abort_o(bus_abort_o), .hold_cancel_o(hold_cancel_o),
    .pins_oe_n_o(pins_oe_n_o), .configuration_port_o(configuration_port_o),
    .configuration_port_oe_o(configuration_port_oe_o), .system_config_o(system_config_o),
    .config_valid_o(config_valid_o), .ale_o(ale_o), .read_strobe_n_o(read_strobe_n_o),
    .write_strobes_n_o(write_strobes_n_o), .fetch_address_o(fetch_address_o),
    .code_segment_o(code_segment_o), .flash_ready_o(flash_ready_o),
    .flash_busy_word_o(flash_busy_word_o)
  );
  arsq_board i_board (.rst_n_o(reset_input_n_i), .mode_o(reset_mode_select_i),
    .ea_n_o(external_access_select_n_i), .cfg_o(configuration_port_i));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = clk_en ? ~mclk_i : mclk_i;
  end
  task automatic tk(input int k);
    repeat (k) @(posedge mclk_i);
    #2;
  endtask : tk
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : cmp
  task automatic wt(output int c);
    c = 0;
    sf = 2'h0;
    while (core_reset_n_o !== 1'b1 && c < 200) begin
      tk(1);
      c++;
      sf |= {flash_busy_word_o === 16'h009B, flash_busy_word_o === 16'hFFFF};
    end
    if (c >= 200) begin
      fails++;
      print_verdict();
    end
  endtask : wt
  task automatic s_power();
    cmp("entry", 32'h6, {reset_output_n_o, bus_abort_o, pins_oe_n_o, core_reset_n_o});
    cmp("pull", 32'hFFFF, configuration_port_o);
    cmp("pull_oe", 32'h0, configuration_port_oe_o);
    i_board.set(1'b0, 1'b0, 1'b0, 16'h3C5A);
    tk(13);
    i_board.set(1'b1, 1'b0, 1'b0, 16'h3C5A);
    wt(n);
    cmp("ext_exit", 32'h1, n > 3 && n < 13);
    cmp("cfg", 32'h3C5A, system_config_o);
    cmp("strobes", 32'h3, {ale_o, read_strobe_n_o, write_strobes_n_o});
    cmp("fetch", 32'h0, {fetch_address_o, code_segment_o});
    cmp("ext_flash_busy", 32'h0, flash_ready_o);
    tk(41);
    cmp("ext_flash_done", 32'h1, flash_ready_o);
    cmp("late_word", 32'h009B, flash_busy_word_o);
  endtask : s_power
  task automatic s_warm();
    i_board.set(1'b0, 1'b1, 1'b1, 16'h0F0F);
    tk(20);
    cmp("warm", 32'h1, core_reset_n_o);
    i_board.set(1'b0, 1'b0, 1'b1, 16'h0F0F);
    tk(1);
    cmp("fall", 32'h0, {core_reset_n_o, reset_output_n_o, ~hold_cancel_o});
    i_board.set(1'b0, 1'b1, 1'b1, 16'h0F0F);
    tk(3);
    cmp("sticky", 32'h0, core_reset_n_o);
    i_board.set(1'b1, 1'b1, 1'b1, 16'h0F0F);
    wt(n);
    cmp("int_exit", 32'h1, n > 40 && n < 57);
    cmp("int_ready", 32'h1, flash_ready_o);
    cmp("flash_words", 32'h3, sf);
  endtask : s_warm
  task automatic s_noclk();
    clk_en = 1'b0;
    #100;
    i_board.set(1'b0, 1'b0, 1'b0, 16'h1234);
    #5;
    cmp("noclk", 32'h1, {core_reset_n_o, reset_output_n_o, pins_oe_n_o});
    clk_en = 1'b1;
    tk(13);
    i_board.set(1'b1, 1'b0, 1'b0, 16'h1234);
    wt(n);
    cmp("cfg2", 32'h1234, system_config_o);
  endtask : s_noclk
  task automatic print_verdict();
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    clk_en = 1'b1;
    arst_n_i = 1'b0;
    fails = 0;
    checks_done = 0;
    tk(3);
    arst_n_i = 1'b1;
    s_power();
    s_warm();
    s_noclk();
    print_verdict();
  end
endmodule : tb_async_reset_sequencer
